// file: rtl/umv_pkg.sv
/*
 * umv_pkg: constants, register map and carrier types for the
 * extended-range motion vector clamp.
 * assumes: included by the main module and its sub-block.
 */
package umv_pkg;

  // --------------------------------------------------------------
  // vector format
  // --------------------------------------------------------------
  localparam int MV_W = 14;
  localparam int COORD_W = 14;

  // --------------------------------------------------------------
  // range thresholds in pixels, limits in half-pixel units
  // --------------------------------------------------------------
  localparam logic [11:0] WID_T1 = 12'd352;
  localparam logic [11:0] WID_T2 = 12'd704;
  localparam logic [11:0] WID_T3 = 12'd1408;
  localparam logic [11:0] HGT_T1 = 12'd288;
  localparam logic [11:0] HGT_T2 = 12'd576;
  localparam logic [11:0] HGT_T3 = 12'd1152;
  localparam logic signed [MV_W-1:0] HALF_N32 = 14'sd64;
  localparam logic signed [MV_W-1:0] HALF_N64 = 14'sd128;
  localparam logic signed [MV_W-1:0] HALF_N128 = 14'sd256;
  localparam logic signed [MV_W-1:0] HALF_N256 = 14'sd512;
  localparam logic signed [MV_W-1:0] HALF_DEF_LO = -14'sd32;
  localparam logic signed [MV_W-1:0] HALF_DEF_HI = 14'sd31;
  localparam logic signed [MV_W-1:0] HALF_EXT_MAX = 14'sd63;
  localparam logic signed [MV_W-1:0] HALF_NOLIM = 14'sd8191;
  localparam logic signed [MV_W-1:0] HALF_PRED_LO = -14'sd31;
  localparam logic signed [MV_W-1:0] HALF_PRED_HI = 14'sd32;
  localparam logic signed [MV_W-1:0] HALF_MOD = 14'sd64;
  localparam logic [MV_W-1:0] MV_ONE = 14'h0001;

  // extrapolation margins, whole pixels
  localparam logic [COORD_W-1:0] EXTRAP_PLUS = 14'd15;
  localparam logic [COORD_W-1:0] EXTRAP_NOPLUS = 14'd32;
  localparam logic [COORD_W-1:0] EXTRAP_OBMC = 14'd16;
  localparam logic [COORD_W-1:0] OBMC_EXTRA = 14'd4;
  localparam logic [COORD_W-1:0] OBMC_EXTRA_RRU = 14'd8;

  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIMS = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RANGE = 8'h0c;
  localparam int CTRL_PT_BIT = 0;
  localparam int CTRL_XPT_BIT = 1;
  localparam int CTRL_PLUS_BIT = 2;
  localparam int CTRL_UUI_LSB = 3;
  localparam int CTRL_OBMC_BIT = 5;
  localparam int CTRL_RRU_BIT = 6;
  localparam logic [1:0] UUI_FORMAT = 2'b10;
  localparam logic [1:0] UUI_NOLIM = 2'b01;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  localparam logic [31:0] DIMS_RESET = 32'h0090_00b0;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic umv_en;
    logic plus_present;
    logic [1:0] unlimited_range_indicator;
    logic obmc;
    logic rru;
    logic [11:0] width;
    logic [11:0] height;
  } umv_cfg_t;

  typedef struct packed {
    logic signed [MV_W-1:0] lo;
    logic signed [MV_W-1:0] hi;
  } umv_range_t;

endpackage : umv_pkg

// file: rtl/umv_axis_clamp.sv
/*
 * umv_axis_clamp: one axis of edge-pixel coordinate limitation.
 * assumes: integer part and half flag of a reference coordinate.
 */
`timescale 1ns/100ps
module umv_axis_clamp import umv_pkg::*; (
  // coordinate in
  input wire logic signed [COORD_W-1:0] coord_i,
  input wire logic half_i,
  input wire logic [11:0] size_i,
  // clamped coordinate out
  output logic signed [COORD_W-1:0] coord_o,
  output logic half_o
);
  logic signed [COORD_W-1:0] last;

  always_comb begin
    last = $signed({2'b00, size_i}) - $signed(MV_ONE);
    coord_o = coord_i;
    half_o = half_i;
    if (coord_i < 0) begin
      coord_o = '0;
      half_o = 1'b0;
    end else if (coord_i >= last) begin
      coord_o = last;
      half_o = 1'b0;
    end
  end
endmodule : umv_axis_clamp

// file: rtl/umv_clamp.sv
/*
 * umv_clamp: motion vector range decision, difference resolution and
 * reference pixel edge clamping, registers over axi4-lite.
 * assumes: one clock, async active-high reset, one request a cycle.
 */
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module umv_clamp import umv_pkg::*; #(
  parameter int TR_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // vector request
  input wire logic req_valid_i,
  input wire logic bidir_i,
  input wire logic signed [MV_W-1:0] cand1_i,
  input wire logic signed [MV_W-1:0] cand2_i,
  input wire logic signed [MV_W-1:0] cand3_i,
  input wire logic signed [MV_W-1:0] coloc_mv_i,
  input wire logic [TR_W-1:0] bidir_temporal_reference_i,
  input wire logic [TR_W-1:0] ref_temporal_distance_i,
  input wire logic signed [MV_W-1:0] vector_difference_i,
  // vector result
  output logic mv_valid_o,
  output logic signed [MV_W-1:0] mv_o,
  output logic mv_range_err_o,
  // reference pixel request (half-pixel units)
  input wire logic ref_valid_i,
  input wire logic signed [COORD_W:0] ref_x_i,
  input wire logic signed [COORD_W:0] ref_y_i,
  // clamped reference
  output logic ref_valid_o,
  output logic signed [COORD_W-1:0] ref_x_o,
  output logic ref_x_half_o,
  output logic signed [COORD_W-1:0] ref_y_o,
  output logic ref_y_half_o,
  output logic ref_reach_err_o
);
  if (TR_W < 1 || TR_W > 12) begin : g_tr_w_chk
    $error("umv_clamp: TR_W out of range");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] dims_q, dims_d;
  logic [15:0] err_cnt_q, err_cnt_d;
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  umv_cfg_t cfg;
  umv_range_t hrange, vrange;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    dims_d = dims_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = AXI_OKAY;
      case (awaddr_q)
        ADDR_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
        ADDR_DIMS: dims_d = merge(dims_q, wdata_q, wstrb_q);
        ADDR_STATUS, ADDR_RANGE: bresp_d = AXI_OKAY;
        default: bresp_d = AXI_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = AXI_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_DIMS: rdata_d = dims_q;
        ADDR_STATUS: rdata_d = {16'h0000, err_cnt_q};
        ADDR_RANGE: rdata_d = {hrange.hi[7:0], vrange.hi[7:0], 16'h0000};
        default: begin
          rdata_d = '0;
          rresp_d = AXI_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      ctrl_q <= '0;
      dims_q <= DIMS_RESET;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      ctrl_q <= ctrl_d;
      dims_q <= dims_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // mode and range decision
  // ----------------------------------------------------------------
  always_comb begin
    cfg.umv_en = ctrl_q[CTRL_PT_BIT] | ctrl_q[CTRL_XPT_BIT];
    cfg.plus_present = ctrl_q[CTRL_PLUS_BIT];
    cfg.unlimited_range_indicator = ctrl_q[CTRL_UUI_LSB +: 2];
    cfg.obmc = ctrl_q[CTRL_OBMC_BIT];
    cfg.rru = ctrl_q[CTRL_RRU_BIT];
    cfg.width = dims_q[11:0];
    cfg.height = dims_q[27:16];
  end

  function automatic logic signed [MV_W-1:0] span(input logic [11:0] sz,
    input logic [11:0] t1, input logic [11:0] t2, input logic [11:0] t3);
    if (sz <= t1) return HALF_N32;
    else if (sz <= t2) return HALF_N64;
    else if (sz <= t3) return HALF_N128;
    else return HALF_N256;
  endfunction : span

  always_comb begin
    hrange.lo = HALF_DEF_LO;
    hrange.hi = HALF_DEF_HI;
    vrange = hrange;
    if (cfg.umv_en && cfg.plus_present) begin
      if (cfg.unlimited_range_indicator == UUI_NOLIM) begin
        hrange.hi = HALF_NOLIM;
        hrange.lo = -HALF_NOLIM;
        vrange = hrange;
      end else begin
        hrange.lo = -span(cfg.width, WID_T1, WID_T2, WID_T3);
        hrange.hi = -hrange.lo - $signed(MV_ONE);
        vrange.lo = -span(cfg.height, HGT_T1, HGT_T2, HGT_T3);
        vrange.hi = -vrange.lo - $signed(MV_ONE);
      end
    end
  end

  // ----------------------------------------------------------------
  // predictor and vector resolution
  // ----------------------------------------------------------------
  logic signed [MV_W-1:0] pred, med, mv_raw, mv_alt, mv_new;
  logic signed [2*MV_W+TR_W:0] prod;
  logic err_new;
  logic mv_valid_q;
  logic signed [MV_W-1:0] mv_q;
  logic mv_err_q;

  always_comb begin
    // median of three
    if ((cand1_i >= cand2_i) == (cand1_i <= cand3_i)) med = cand1_i;
    else if ((cand2_i >= cand1_i) == (cand2_i <= cand3_i)) med = cand2_i;
    else med = cand3_i;
    prod = coloc_mv_i * $signed({1'b0, bidir_temporal_reference_i});
    if (ref_temporal_distance_i == '0) begin
      pred = '0;
    end else begin
      pred = MV_W'(prod / $signed({1'b0, ref_temporal_distance_i}));
    end
    if (!bidir_i) pred = med;
    mv_raw = pred + vector_difference_i;
    mv_alt = (mv_raw > 0) ? mv_raw - HALF_MOD : mv_raw + HALF_MOD;
    mv_new = mv_raw;
    err_new = 1'b0;
    if (cfg.umv_en && !cfg.plus_present) begin
      if (pred < HALF_PRED_LO || pred > HALF_PRED_HI) begin
        if ((pred < 0 && mv_raw > 0) || (pred > 0 && mv_raw < 0) ||
            mv_raw > HALF_EXT_MAX || mv_raw < -HALF_EXT_MAX) begin
          mv_new = mv_alt;
        end
      end
      if (mv_new > HALF_EXT_MAX || mv_new < -HALF_EXT_MAX) begin
        err_new = 1'b1;
      end
    end else if (cfg.umv_en) begin
      err_new = (mv_new < hrange.lo) || (mv_new > hrange.hi);
    end else begin
      err_new = (mv_new < HALF_DEF_LO) || (mv_new > HALF_DEF_HI);
    end
  end

  // ----------------------------------------------------------------
  // reference pixel clamp
  // ----------------------------------------------------------------
  logic signed [COORD_W-1:0] ix, iy, cx, cy, reach;
  logic hx, hy, chx, chy, reach_err;
  logic ref_valid_q, ref_hx_q, ref_hy_q, ref_err_q;
  logic signed [COORD_W-1:0] ref_x_q, ref_y_q;

  always_comb begin
    ix = ref_x_i[COORD_W:1];
    hx = ref_x_i[0];
    iy = ref_y_i[COORD_W:1];
    hy = ref_y_i[0];
    if (cfg.plus_present) reach = $signed(EXTRAP_PLUS);
    else if (cfg.umv_en) reach = $signed(EXTRAP_NOPLUS);
    else reach = $signed(EXTRAP_OBMC);
    if (cfg.obmc) begin
      reach = reach + $signed(cfg.rru ? OBMC_EXTRA_RRU : OBMC_EXTRA);
    end
    reach_err = (ix < -reach) || (iy < -reach) ||
      (ix >= $signed({2'b00, cfg.width}) + reach) ||
      (iy >= $signed({2'b00, cfg.height}) + reach);
  end

  umv_axis_clamp u_clamp_x (
    .coord_i(ix),
    .half_i(hx),
    .size_i(cfg.width),
    .coord_o(cx),
    .half_o(chx)
  );

  umv_axis_clamp u_clamp_y (
    .coord_i(iy),
    .half_i(hy),
    .size_i(cfg.height),
    .coord_o(cy),
    .half_o(chy)
  );

  always_comb begin
    err_cnt_d = err_cnt_q;
    if ((req_valid_i && err_new) || (ref_valid_i && reach_err)) begin
      err_cnt_d = err_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mv_valid_q <= 1'b0;
      mv_q <= '0;
      mv_err_q <= 1'b0;
      ref_valid_q <= 1'b0;
      ref_x_q <= '0;
      ref_y_q <= '0;
      ref_hx_q <= 1'b0;
      ref_hy_q <= 1'b0;
      ref_err_q <= 1'b0;
      err_cnt_q <= '0;
    end else begin
      mv_valid_q <= req_valid_i;
      mv_q <= mv_new;
      mv_err_q <= err_new;
      ref_valid_q <= ref_valid_i;
      ref_x_q <= cfg.umv_en ? cx : ix;
      ref_y_q <= cfg.umv_en ? cy : iy;
      ref_hx_q <= cfg.umv_en ? chx : hx;
      ref_hy_q <= cfg.umv_en ? chy : hy;
      ref_err_q <= reach_err;
      err_cnt_q <= err_cnt_d;
    end
  end

  assign mv_valid_o = mv_valid_q;
  assign mv_o = mv_q;
  assign mv_range_err_o = mv_err_q;
  assign ref_valid_o = ref_valid_q;
  assign ref_x_o = ref_x_q;
  assign ref_y_o = ref_y_q;
  assign ref_x_half_o = ref_hx_q;
  assign ref_y_half_o = ref_hy_q;
  assign ref_reach_err_o = ref_err_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_clamp_lo;
    @(posedge clk_i) disable iff (reset_i)
      ref_valid_i && cfg.umv_en && ix < 0 |=> ref_x_o == 0 && !ref_x_half_o;
  endproperty
  a_clamp_lo: assert property (p_clamp_lo) else $error("x low clamp");

  property p_clamp_hi;
    @(posedge clk_i) disable iff (reset_i)
      ref_valid_i && cfg.umv_en && iy >= $signed({2'b00, cfg.height})
      |=> ref_y_o == $signed({2'b00, cfg.height}) - 1;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("y high clamp");

  property p_inside_half;
    @(posedge clk_i) disable iff (reset_i)
      ref_valid_i && ix == 0 && hx |=> ref_x_half_o;
  endproperty
  a_inside_half: assert property (p_inside_half) else $error("half lost");

  property p_ext_bound;
    @(posedge clk_i) disable iff (reset_i)
      req_valid_i && cfg.umv_en && !cfg.plus_present && !err_new
      |=> mv_o <= HALF_EXT_MAX && mv_o >= -HALF_EXT_MAX;
  endproperty
  a_ext_bound: assert property (p_ext_bound) else $error("ext range");

  property p_sign;
    @(posedge clk_i) disable iff (reset_i)
      req_valid_i && cfg.umv_en && !cfg.plus_present && pred > HALF_PRED_HI
      && !err_new |=> mv_o >= 0;
  endproperty
  a_sign: assert property (p_sign) else $error("sign of far pred");

  property p_default;
    @(posedge clk_i) disable iff (reset_i)
      req_valid_i && !cfg.umv_en && (mv_new > HALF_DEF_HI) |=> mv_range_err_o;
  endproperty
  a_default: assert property (p_default) else $error("default range");

  property p_fmt;
    @(posedge clk_i) disable iff (reset_i)
      cfg.umv_en && cfg.plus_present && cfg.unlimited_range_indicator != UUI_NOLIM &&
      cfg.width <= WID_T1 |-> hrange.hi == HALF_N32 - 1;
  endproperty
  a_fmt: assert property (p_fmt) else $error("width range");

  property p_median;
    @(posedge clk_i) disable iff (reset_i)
      req_valid_i && !bidir_i && !cfg.umv_en |=>
      mv_o == $past(med) + $past(vector_difference_i);
  endproperty
  a_median: assert property (p_median) else $error("median pred");

endmodule : umv_clamp

// file: tb/umv_enc_model.sv
/*
 * umv_enc_model: encoder side, issues vector and reference requests.
 * assumes: driven by tasks of tb, changes lines after rising edges.
 */
`timescale 1ns/100ps
module umv_enc_model import umv_pkg::*; (
  // clock
  input wire logic clk_i,
  // vector request
  output logic req_valid_o,
  output logic bidir_o,
  output logic signed [MV_W-1:0] cand1_o,
  output logic signed [MV_W-1:0] cand2_o,
  output logic signed [MV_W-1:0] cand3_o,
  output logic signed [MV_W-1:0] coloc_o,
  output logic [7:0] trb_o,
  output logic [7:0] trd_o,
  output logic signed [MV_W-1:0] diff_o,
  // reference request
  output logic ref_valid_o,
  output logic signed [COORD_W:0] ref_x_o,
  output logic signed [COORD_W:0] ref_y_o
);
  initial begin
    {req_valid_o, bidir_o, cand1_o, cand2_o, cand3_o, coloc_o} = '0;
    {trb_o, trd_o, diff_o, ref_valid_o, ref_x_o, ref_y_o} = '0;
  end

  // ------------------------------------------------------------
  // one vector component a cycle, values cut to MV_W bits, temporal references to 8, not range-checked
  // ------------------------------------------------------------
  task mv(input bit b, input int a1, input int a2, input int a3,
          input int co, input int tb_, input int td, input int d);
    req_valid_o <= 1'h1;
    ref_valid_o <= 1'h0;
    bidir_o <= b;
    cand1_o <= MV_W'(a1);
    cand2_o <= MV_W'(a2);
    cand3_o <= MV_W'(a3);
    coloc_o <= MV_W'(co);
    trb_o <= 8'(tb_);
    trd_o <= 8'(td);
    diff_o <= MV_W'(d);
    @(posedge clk_i);
  endtask : mv

  task rf(input int x, input int y);
    ref_valid_o <= 1'h1;
    req_valid_o <= 1'h0;
    ref_x_o <= 15'(x);
    ref_y_o <= 15'(y);
    @(posedge clk_i);
  endtask : rf

  // diff_o and ref_x_o invert so they stop showing the last value
  task idle();
    req_valid_o <= 1'h0;
    ref_valid_o <= 1'h0;
    diff_o <= ~diff_o;
    ref_x_o <= ~ref_x_o;
    @(posedge clk_i);
  endtask : idle
endmodule : umv_enc_model

// file: tb/tb.sv
/*
 * tb: self-checking bench for umv_clamp, axi4-lite master and encoder.
 * assumes: 25 mhz clock, registered one-cycle answers on both paths.
 */
`timescale 1ns/100ps
module tb import umv_pkg::*;;
  logic clk_i, reset_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic req_v, bidir, ref_v, mv_valid_o, mv_range_err_o, ref_valid_o;
  logic signed [MV_W-1:0] c1, c2, c3, co, dif, mv_o;
  logic [7:0] bidir_temporal_reference, ref_temporal_distance;
  logic signed [COORD_W:0] rx, ry;
  logic signed [COORD_W-1:0] ref_x_o, ref_y_o;
  logic ref_x_half_o, ref_y_half_o, ref_reach_err_o;
  logic [14:0] qm[$];
  logic [30:0] qr[$];
  int fails = 0, n_checks = 0;
  int lo = -32, hi = 31, rch = 0;

  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end

  umv_enc_model enc_u (.clk_i(clk_i), .req_valid_o(req_v),
    .bidir_o(bidir), .cand1_o(c1), .cand2_o(c2), .cand3_o(c3),
    .coloc_o(co), .trb_o(bidir_temporal_reference), .trd_o(ref_temporal_distance), .diff_o(dif),
    .ref_valid_o(ref_v), .ref_x_o(rx), .ref_y_o(ry));

  umv_clamp #(.TR_W(8)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .req_valid_i(req_v), .bidir_i(bidir),
    .cand1_i(c1), .cand2_i(c2), .cand3_i(c3), .coloc_mv_i(co),
    .bidir_temporal_reference_i(bidir_temporal_reference), .ref_temporal_distance_i(ref_temporal_distance),
    .vector_difference_i(dif), .mv_valid_o(mv_valid_o), .mv_o(mv_o),
    .mv_range_err_o(mv_range_err_o), .ref_valid_i(ref_v),
    .ref_x_i(rx), .ref_y_i(ry), .ref_valid_o(ref_valid_o),
    .ref_x_o(ref_x_o), .ref_x_half_o(ref_x_half_o), .ref_y_o(ref_y_o),
    .ref_y_half_o(ref_y_half_o), .ref_reach_err_o(ref_reach_err_o));

  // ------------------------------------------------------------
  // compare, verdict
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask : chk

  task final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // axi4-lite master
  // ------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk_i);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_i);
  endtask : rd

  // ------------------------------------------------------------
  // expected values
  // ------------------------------------------------------------
  function automatic int emv(input int p, input int d, input bit pl);
    int m;
    m = p + d;
    if (pl || (p >= -31 && p <= 32)) return m;
    if (p > 32 && (m < 0 || m > 63)) m = m + ((m < 0) ? 64 : -64);
    if (p < -31 && (m > 0 || m < -63)) m = m + ((m > 0) ? -64 : 64);
    return m;
  endfunction : emv

  function automatic logic [14:0] eref(input int v, input int sz);
    if (v < 0) return 15'h0;
    if (v >= 2 * (sz - 1)) return {14'(sz - 1), 1'h0};
    return {14'(v >>> 1), v[0]};
  endfunction : eref

  task v(input int a, input int b, input int c, input int d, input bit pl);
    int md;
    int m;
    md = (a < b) ? a : b;
    md = ((a > b ? a : b) < c) ? (a > b ? a : b) : ((md > c) ? md : c);
    m = emv(md, d, pl);
    qm.push_back({m < lo || m > hi, 14'(m)});
    enc_u.mv(1'h0, a, b, c, 0, 0, 1, d);
  endtask : v

  task vb(input int cm, input int t1, input int t2, input int d);
    int m;
    m = emv(cm * t1 / t2, d, 1'h0);
    qm.push_back({m < lo || m > hi, 14'(m)});
    enc_u.mv(1'h1, 0, 0, 0, cm, t1, t2, d);
  endtask : vb

  task r(input int x, input int y, input int w, input int h);
    bit e;
    e = (x >>> 1) < -rch || (y >>> 1) < -rch ||
        (x >>> 1) >= w + rch || (y >>> 1) >= h + rch;
    qr.push_back({e, eref(x, w), eref(y, h)});
    enc_u.rf(x, y);
  endtask : r

  // ------------------------------------------------------------
  // result watcher
  // ------------------------------------------------------------
  always @(negedge clk_i) begin
    if (mv_valid_o === 1'h1) begin
      chk("mv", {17'h0, mv_range_err_o, mv_o},
          qm.size() ? {17'h0, qm.pop_front()} : 'x);
    end
    if (ref_valid_o === 1'h1) begin
      chk("ref", {1'h0, ref_reach_err_o, ref_x_o, ref_x_half_o,
          ref_y_o, ref_y_half_o}, qr.size() ? {1'h0, qr.pop_front()} : 'x);
    end
  end

  initial begin
    #(40 * 4000);
    fails++;
    final_report();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_i = 1'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(72862));
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    @(posedge clk_i);
    rd(ADDR_DIMS, 32'h0090_00b0, AXI_OKAY);
    rd(ADDR_CTRL, 32'h0, AXI_OKAY);
    v(0, 0, 0, 40, 0);
    enc_u.idle();
    wr(8'h10, 32'h5, AXI_SLVERR);
    rd(8'h10, 32'h0, AXI_SLVERR);
    wr(ADDR_STATUS, 32'hffff, AXI_OKAY);
    wr(ADDR_CTRL, 32'h1, AXI_OKAY);
    lo = -63;
    hi = 63;
    rch = 32;
    v(0, 0, 0, 70, 0);
    v(5, -3, 10, 7, 0);
    v(10, 5, -3, 7, 0);
    v(-3, 10, 5, -20, 0);
    v(40, 40, 40, -50, 0);
    v(-40, -40, -40, 50, 0);
    v(32, 32, 32, -48, 0);
    v(33, 33, 33, -40, 0);
    vb(21, 2, 3, 1);
    vb(-21, 1, 2, -2);
    r(-1, -1, 176, 144);
    r(1, 1, 176, 144);
    r(349, 287, 176, 144);
    r(350, 286, 176, 144);
    r(351, 288, 176, 144);
    for (int i = 0; i < 16; i++) begin
      r(int'($urandom_range(470)) - 60, int'($urandom_range(350)) - 60,
        176, 144);
    end
    enc_u.idle();
    wr(ADDR_CTRL, 32'h61, AXI_OKAY);
    rch = 40;
    r(-80, 0, 176, 144);
    r(-82, 300, 176, 144);
    enc_u.idle();
    wr(ADDR_CTRL, 32'h16, AXI_OKAY);
    lo = -64;
    hi = 63;
    rch = 15;
    rd(ADDR_CTRL, 32'h16, AXI_OKAY);
    rd(ADDR_RANGE, 32'h3f3f_0000, AXI_OKAY);
    v(40, 40, 40, -50, 1);
    r(-10, 300, 176, 144);
    enc_u.idle();
    wr(ADDR_DIMS, 32'h00c8_0190, AXI_OKAY);
    rd(ADDR_RANGE, 32'h7f3f_0000, AXI_OKAY);
    r(799, 397, 400, 200);
    r(800, 398, 400, 200);
    enc_u.idle();
    wr(ADDR_CTRL, 32'h0e, AXI_OKAY);
    lo = -8191;
    hi = 8191;
    v(200, 200, 200, 100, 1);
    enc_u.idle();
    repeat (3) @(posedge clk_i);
    chk("left", qm.size() + qr.size(), 0);
    rd(ADDR_STATUS, 32'h3, AXI_OKAY);
    final_report();
  end
endmodule : tb
